// *** pllc_pkg.sv ***
// shared constants and types for the pll and distribution configuration block
package pllc_pkg;
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;
   localparam int PIN_N = 4;
   // register offsets, as the map prints them
   localparam logic [8:0] OFS_PUMP_CUR = 9'h00f;
   localparam logic [8:0] OFS_PLL_MAIN = 9'h010;
   localparam logic [8:0] OFS_DET_CTL = 9'h017;
   localparam logic [8:0] OFS_CAL_CTL = 9'h018;
   localparam logic [8:0] OFS_STATUS = 9'h01f;
   localparam logic [8:0] OFS_DIV_SEL = 9'h1e0;
   localparam logic [8:0] OFS_DIST_SEL = 9'h1e1;
   // field positions
   localparam int PD_LSB = 0;
   localparam int CPM_LSB = 4;
   localparam int POL_BIT = 7;
   localparam int ABP_LSB = 0;
   localparam int CAL_BIT = 0;
   localparam int BYP_BIT = 0;
   localparam int SRC_BIT = 1;
   localparam int DIV_LSB = 0;
   localparam int CUR_LSB = 0;
   // reset values
   localparam logic [7:0] RST_PLL_MAIN = 8'h01;
   localparam logic [7:0] RST_DET_CTL = 8'h00;
   localparam logic [7:0] RST_CAL_CTL = 8'h00;
   localparam logic [7:0] RST_DIV_SEL = 8'h02;
   localparam logic [7:0] RST_DIST_SEL = 8'h00;
   localparam logic [7:0] RST_PUMP_CUR = 8'h07;
   // power-down field codes
   localparam logic [1:0] PD_NORMAL = 2'h0;
   localparam logic [1:0] PD_ASYNC = 2'h1;
   // prescaler: code 0..4 gives divide-by-2..6
   localparam logic [2:0] DIV_BASE = 3'h2;
   localparam logic [2:0] DIV_CODE_MAX = 3'h4;
   // pump current: code n means (n+1) steps of the lsb
   localparam int PUMP_LSB_UA = 600;
   localparam int PUMP_STEPS = 8;
   // antibacklash count limit per width code; the hold lasts this many core clock cycles plus one
   localparam logic [3:0] ABP_CYC_0 = 4'h1;
   localparam logic [3:0] ABP_CYC_1 = 4'h2;
   localparam logic [3:0] ABP_CYC_2 = 4'h3;
   localparam logic [3:0] ABP_CYC_3 = 4'h4;
   typedef enum logic [2:0] {
      CPM_HIZ = 3'b000,
      CPM_UP = 3'b001,
      CPM_DN = 3'b010,
      CPM_NORMAL = 3'b011
   } pllc_cpm_t;
endpackage

// *** pllc_cfg_if.sv ***
// configuration carried from the register file to the detector and clock path
`timescale 1ns/1ps
interface pllc_cfg_if;
   logic pll_on;
   pllc_pkg::pllc_cpm_t cp_mode;
   logic invert;
   logic [1:0] abp_code;
   logic src_int;
   logic bypass;
   logic [2:0] div_code;
   modport src (output pll_on, cp_mode, invert, abp_code, src_int, bypass, div_code);
   modport pfd (input pll_on, cp_mode, invert, abp_code);
   modport sel (input src_int, bypass, div_code);
endinterface

// *** pllc_pfd.sv ***
// phase-frequency detector with antibacklash hold and charge pump mode decode
`timescale 1ns/1ps
module pllc_pfd (
   input wire logic core_clk,
   input wire logic sys_rst,
   pllc_cfg_if.pfd cfg,
   input wire logic ref_lvl,
   input wire logic fb_lvl,
   output logic pump_up,
   output logic pump_dn,
   output logic pump_hiz
);
   import pllc_pkg::*;
   logic ref_q_r, ref_q_nxt, fb_q_r, fb_q_nxt;
   logic up_r, up_nxt, dn_r, dn_nxt;
   logic [3:0] abp_cnt_r, abp_cnt_nxt, abp_lim;
   logic pu_nxt, pd_nxt, hiz_nxt;

   always_comb begin
      ref_q_nxt = ref_lvl;
      fb_q_nxt = fb_lvl;
      up_nxt = up_r;
      dn_nxt = dn_r;
      abp_cnt_nxt = abp_cnt_r;
      case (cfg.abp_code)
         2'h0: abp_lim = ABP_CYC_0;
         2'h1: abp_lim = ABP_CYC_1;
         2'h2: abp_lim = ABP_CYC_2;
         default: abp_lim = ABP_CYC_3;
      endcase
      if (!cfg.pll_on) begin
         up_nxt = 1'b0;
         dn_nxt = 1'b0;
         abp_cnt_nxt = 4'h0;
      end else if (up_r && dn_r) begin
         // both sides fired: hold both for the antibacklash width, then clear
         if (abp_cnt_r >= abp_lim) begin
            up_nxt = ref_lvl && !ref_q_r;
            dn_nxt = fb_lvl && !fb_q_r;
            abp_cnt_nxt = 4'h0;
         end else begin
            abp_cnt_nxt = abp_cnt_r + 4'h1;
         end
      end else begin
         if (ref_lvl && !ref_q_r) up_nxt = 1'b1;
         if (fb_lvl && !fb_q_r) dn_nxt = 1'b1;
      end
      pu_nxt = 1'b0;
      pd_nxt = 1'b0;
      hiz_nxt = 1'b1;
      if (cfg.pll_on) begin
         case (cfg.cp_mode)
            CPM_NORMAL: begin
               // negative polarity swaps the pump direction
               pu_nxt = cfg.invert ? dn_r : up_r;
               pd_nxt = cfg.invert ? up_r : dn_r;
               hiz_nxt = 1'b0;
            end
            CPM_UP: begin
               pu_nxt = 1'b1;
               hiz_nxt = 1'b0;
            end
            CPM_DN: begin
               pd_nxt = 1'b1;
               hiz_nxt = 1'b0;
            end
            default: hiz_nxt = 1'b1;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ref_q_r <= 1'b0;
         fb_q_r <= 1'b0;
         up_r <= 1'b0;
         dn_r <= 1'b0;
         abp_cnt_r <= 4'h0;
         pump_up <= 1'b0;
         pump_dn <= 1'b0;
         pump_hiz <= 1'b1;
      end else begin
         ref_q_r <= ref_q_nxt;
         fb_q_r <= fb_q_nxt;
         up_r <= up_nxt;
         dn_r <= dn_nxt;
         abp_cnt_r <= abp_cnt_nxt;
         pump_up <= pu_nxt;
         pump_dn <= pd_nxt;
         pump_hiz <= hiz_nxt;
      end
   end

   property p_ref_edge_up;
      @(posedge core_clk) disable iff (sys_rst)
      cfg.pll_on && ref_lvl && !ref_q_r && !up_r |=> up_r;
   endproperty
   a_ref_edge_up: assert property (p_ref_edge_up) else $error("reference edge did not raise up");

   property p_polarity;
      @(posedge core_clk) disable iff (sys_rst)
      cfg.pll_on && cfg.cp_mode == CPM_NORMAL
         |=> pump_up == $past(cfg.invert ? dn_r : up_r) && pump_dn == $past(cfg.invert ? up_r : dn_r) && !pump_hiz;
   endproperty
   a_polarity: assert property (p_polarity) else $error("pump direction ignores polarity");

   property p_const_up;
      @(posedge core_clk) disable iff (sys_rst)
      cfg.pll_on && cfg.cp_mode == CPM_UP |=> pump_up && !pump_dn && !pump_hiz;
   endproperty
   a_const_up: assert property (p_const_up) else $error("constant pump up not driven");

   property p_hiz_mode;
      @(posedge core_clk) disable iff (sys_rst)
      cfg.cp_mode == CPM_HIZ || !cfg.pll_on |=> pump_hiz && !pump_up && !pump_dn;
   endproperty
   a_hiz_mode: assert property (p_hiz_mode) else $error("pump not high impedance");

   property p_abp_width;
      @(posedge core_clk) disable iff (sys_rst)
      up_r && dn_r && cfg.pll_on && cfg.abp_code == 2'h1 && abp_cnt_r == 4'h0 && $stable(cfg.abp_code)
         |=> (up_r && dn_r) [*2] ##1 !(up_r && dn_r);
   endproperty
   a_abp_width: assert property (p_abp_width) else $error("antibacklash hold has wrong width");
endmodule

// *** pllc_clk_sel.sv ***
// source select and divide-by-2..6 prescaler feeding the distribution section
`timescale 1ns/1ps
module pllc_clk_sel (
   input wire logic core_clk,
   input wire logic sys_rst,
   pllc_cfg_if.sel cfg,
   input wire logic ext_lvl,
   input wire logic int_lvl,
   output logic dist_clk
);
   import pllc_pkg::*;
   logic src, src_q_r, src_q_nxt;
   logic [2:0] cnt_r, cnt_nxt, ratio;
   logic div_r, div_nxt, dist_nxt;

   always_comb begin
      src = cfg.src_int ? int_lvl : ext_lvl;
      // out-of-range codes clamp to the largest divide
      ratio = (cfg.div_code > DIV_CODE_MAX) ? DIV_CODE_MAX + DIV_BASE : cfg.div_code + DIV_BASE;
      src_q_nxt = src;
      cnt_nxt = cnt_r;
      div_nxt = div_r;
      if (cfg.bypass) begin
         cnt_nxt = 3'h0;
         dist_nxt = src;
      end else begin
         // each source edge is a half period: toggling every ratio edges divides by ratio
         if (src != src_q_r) begin
            if (cnt_r >= ratio - 3'h1) begin
               cnt_nxt = 3'h0;
               div_nxt = !div_r;
            end else begin
               cnt_nxt = cnt_r + 3'h1;
            end
         end
         dist_nxt = div_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         src_q_r <= 1'b0;
         cnt_r <= 3'h0;
         div_r <= 1'b0;
         dist_clk <= 1'b0;
      end else begin
         src_q_r <= src_q_nxt;
         cnt_r <= cnt_nxt;
         div_r <= div_nxt;
         dist_clk <= dist_nxt;
      end
   end

   property p_bypass_ext;
      @(posedge core_clk) disable iff (sys_rst)
      cfg.bypass && !cfg.src_int |=> dist_clk == $past(ext_lvl);
   endproperty
   a_bypass_ext: assert property (p_bypass_ext) else $error("external clock not passed straight");

   property p_bypass_int;
      @(posedge core_clk) disable iff (sys_rst)
      cfg.bypass && cfg.src_int |=> dist_clk == $past(int_lvl);
   endproperty
   a_bypass_int: assert property (p_bypass_int) else $error("internal oscillator not passed straight");

   property p_div_hold;
      @(posedge core_clk) disable iff (sys_rst)
      !cfg.bypass && $past(!cfg.bypass) && src == src_q_r |=> $stable(dist_clk);
   endproperty
   a_div_hold: assert property (p_div_hold) else $error("divided clock moved without source edge");
endmodule

// *** pllc_top.sv ***
// register file and top level of the pll and distribution configuration block
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module pllc_top (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [pllc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [pllc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [pllc_pkg::DATA_W-1:0] reg_rdata,
   input wire logic ref_div_in,
   input wire logic fb_div_in,
   input wire logic ext_clk_in,
   input wire logic int_osc_in,
   output logic charge_pump_up,
   output logic charge_pump_dn,
   output logic charge_pump_hiz,
   output logic [2:0] pump_current_code,
   output logic [1:0] abp_width_code,
   output logic pll_powered_down,
   output logic int_osc_enable,
   output logic cal_start,
   output logic dist_clk
);
   import pllc_pkg::*;
   logic [PIN_N-1:0] pin_in, pin_lvl;
   logic [7:0] pll_main_r, pll_main_nxt;
   logic [7:0] det_ctl_r, det_ctl_nxt;
   logic [7:0] cal_ctl_r, cal_ctl_nxt;
   logic [7:0] div_sel_r, div_sel_nxt;
   logic [7:0] dist_sel_r, dist_sel_nxt;
   logic [7:0] pump_cur_r, pump_cur_nxt;
   logic [7:0] rdata_nxt, status;
   logic cal_need_r, cal_need_nxt, loop_int_q_r, loop_int, cal_start_nxt;
   logic pll_pd_nxt, int_en_nxt;
   logic [2:0] cur_nxt;
   logic [1:0] abp_nxt;
   pllc_cfg_if cfg_bus ();

   // every pin input is retimed by two flops before any logic sees it
   assign pin_in = {int_osc_in, ext_clk_in, fb_div_in, ref_div_in};
   for (genvar i = 0; i < PIN_N; i++) begin : g_sync
      logic s1_r, s2_r;
      always_ff @(posedge core_clk) begin
         if (sys_rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
         end else begin
            s1_r <= pin_in[i];
            s2_r <= s1_r;
         end
      end
      assign pin_lvl[i] = s2_r;
   end

   assign cfg_bus.pll_on = pll_main_r[PD_LSB +: 2] == PD_NORMAL;
   assign cfg_bus.cp_mode = pllc_cpm_t'(pll_main_r[CPM_LSB +: 3]);
   // the internal oscillator has fixed polarity, so the bit only matters externally
   assign cfg_bus.invert = pll_main_r[POL_BIT] && !dist_sel_r[SRC_BIT];
   assign cfg_bus.abp_code = det_ctl_r[ABP_LSB +: 2];
   assign cfg_bus.src_int = dist_sel_r[SRC_BIT];
   assign cfg_bus.bypass = dist_sel_r[BYP_BIT];
   assign cfg_bus.div_code = div_sel_r[DIV_LSB +: 3];
   assign loop_int = cfg_bus.pll_on && cfg_bus.src_int;
   assign status = {4'h0, dist_clk, cal_need_r, int_osc_enable, !pll_powered_down};

   always_comb begin
      pll_main_nxt = pll_main_r;
      det_ctl_nxt = det_ctl_r;
      cal_ctl_nxt = cal_ctl_r;
      div_sel_nxt = div_sel_r;
      dist_sel_nxt = dist_sel_r;
      pump_cur_nxt = pump_cur_r;
      cal_start_nxt = 1'b0;
      if (reg_wr) begin
         case (reg_addr)
            OFS_PLL_MAIN: pll_main_nxt = reg_wdata;
            OFS_DET_CTL: det_ctl_nxt = reg_wdata;
            OFS_DIV_SEL: div_sel_nxt = reg_wdata;
            OFS_DIST_SEL: dist_sel_nxt = reg_wdata;
            OFS_PUMP_CUR: pump_cur_nxt = reg_wdata;
            OFS_CAL_CTL: begin
               cal_ctl_nxt = reg_wdata;
               // a calibration starts on the 0 to 1 step of the bit only
               cal_start_nxt = reg_wdata[CAL_BIT] && !cal_ctl_r[CAL_BIT];
            end
            default: ;
         endcase
      end
      rdata_nxt = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            OFS_PLL_MAIN: rdata_nxt = pll_main_r;
            OFS_DET_CTL: rdata_nxt = det_ctl_r;
            OFS_CAL_CTL: rdata_nxt = cal_ctl_r;
            OFS_DIV_SEL: rdata_nxt = div_sel_r;
            OFS_DIST_SEL: rdata_nxt = dist_sel_r;
            OFS_PUMP_CUR: rdata_nxt = pump_cur_r;
            OFS_STATUS: rdata_nxt = status;
            default: rdata_nxt = 8'h00;
         endcase
      end
      // entering the internal loop asks for calibration; the set beats the clear
      cal_need_nxt = (cal_need_r && !cal_start) || (loop_int && !loop_int_q_r);
      pll_pd_nxt = !cfg_bus.pll_on;
      int_en_nxt = loop_int;
      cur_nxt = pump_cur_r[CUR_LSB +: 3];
      abp_nxt = det_ctl_r[ABP_LSB +: 2];
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pll_main_r <= RST_PLL_MAIN;
         det_ctl_r <= RST_DET_CTL;
         cal_ctl_r <= RST_CAL_CTL;
         div_sel_r <= RST_DIV_SEL;
         dist_sel_r <= RST_DIST_SEL;
         pump_cur_r <= RST_PUMP_CUR;
         reg_rdata <= 8'h00;
         cal_need_r <= 1'b0;
         loop_int_q_r <= 1'b0;
         cal_start <= 1'b0;
         pll_powered_down <= 1'b1;
         int_osc_enable <= 1'b0;
         pump_current_code <= 3'h0;
         abp_width_code <= 2'h0;
      end else begin
         pll_main_r <= pll_main_nxt;
         det_ctl_r <= det_ctl_nxt;
         cal_ctl_r <= cal_ctl_nxt;
         div_sel_r <= div_sel_nxt;
         dist_sel_r <= dist_sel_nxt;
         pump_cur_r <= pump_cur_nxt;
         reg_rdata <= rdata_nxt;
         cal_need_r <= cal_need_nxt;
         loop_int_q_r <= loop_int;
         cal_start <= cal_start_nxt;
         pll_powered_down <= pll_pd_nxt;
         int_osc_enable <= int_en_nxt;
         pump_current_code <= cur_nxt;
         abp_width_code <= abp_nxt;
      end
   end

   pllc_pfd pllc_pfd_i (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .cfg(cfg_bus.pfd),
      .ref_lvl(pin_lvl[0]),
      .fb_lvl(pin_lvl[1]),
      .pump_up(charge_pump_up),
      .pump_dn(charge_pump_dn),
      .pump_hiz(charge_pump_hiz)
   );

   pllc_clk_sel pllc_clk_sel_i (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .cfg(cfg_bus.sel),
      .ext_lvl(pin_lvl[2]),
      .int_lvl(pin_lvl[3]),
      .dist_clk(dist_clk)
   );

   property p_pd_off;
      @(posedge core_clk) disable iff (sys_rst)
      reg_wr && reg_addr == OFS_PLL_MAIN && reg_wdata[PD_LSB +: 2] == PD_ASYNC ##1 !(reg_wr && reg_addr == OFS_PLL_MAIN)
         |=> pll_powered_down && charge_pump_hiz;
   endproperty
   a_pd_off: assert property (p_pd_off) else $error("pll not powered down after 01b");

   property p_pd_on;
      @(posedge core_clk) disable iff (sys_rst)
      reg_wr && reg_addr == OFS_PLL_MAIN && reg_wdata[PD_LSB +: 2] == PD_NORMAL |-> ##2 !pll_powered_down;
   endproperty
   a_pd_on: assert property (p_pd_on) else $error("pll not running after 00b");

   property p_reset_default;
      @(posedge core_clk) disable iff (sys_rst)
      $past(sys_rst) |-> pll_main_r[PD_LSB +: 2] == PD_ASYNC && !dist_sel_r[SRC_BIT] && !dist_sel_r[BYP_BIT];
   endproperty
   a_reset_default: assert property (p_reset_default) else $error("wrong state after reset");

   property p_pump_current;
      @(posedge core_clk) disable iff (sys_rst)
      reg_wr && reg_addr == OFS_PUMP_CUR ##1 !(reg_wr && reg_addr == OFS_PUMP_CUR)
         |=> pump_current_code == $past(reg_wdata[2:0], 2);
   endproperty
   a_pump_current: assert property (p_pump_current) else $error("pump current code not applied");

   property p_pol_internal;
      @(posedge core_clk) disable iff (sys_rst)
      dist_sel_r[SRC_BIT] && pll_main_r[POL_BIT] && cfg_bus.pll_on && cfg_bus.cp_mode == CPM_NORMAL
         |=> charge_pump_up == $past(pllc_pfd_i.up_r);
   endproperty
   a_pol_internal: assert property (p_pol_internal) else $error("polarity acted on internal oscillator");

   property p_cal_pulse;
      @(posedge core_clk) disable iff (sys_rst)
      // a new internal-loop entry in the same cycle sets the flag again, by design
      cal_start && !(loop_int && !loop_int_q_r) |=> !cal_start && !cal_need_r ##1 !cal_start;
   endproperty
   a_cal_pulse: assert property (p_cal_pulse) else $error("calibration start not a single pulse");
endmodule

// *** pllc_src_model.sv ***
// external clock source, internal oscillator and divider-output pins seen by the block
`timescale 1ns/1ps
module pllc_src_model #(
   parameter int EXT_HALF_NS = 100,
   parameter int INT_HALF_NS = 150,
   parameter int HOLD_NS = 1000
) (
   input wire logic int_osc_enable,
   input wire logic pfd_go,
   input wire logic [15:0] fb_lag_ns,
   output logic ref_div_in,
   output logic fb_div_in,
   output logic ext_clk_in,
   output logic int_osc_in
);
   initial begin
      ref_div_in = 1'b0;
      fb_div_in = 1'b0;
      ext_clk_in = 1'b0;
      int_osc_in = 1'b0;
   end
   // both sources run far below the channel divider limit, bypassed or not
   always #(EXT_HALF_NS) ext_clk_in = ~ext_clk_in;
   // oscillator is dark while unpowered, so a stale level cannot pass for a clock
   always #(INT_HALF_NS) begin
      if (int_osc_enable === 1'b1) int_osc_in = ~int_osc_in;
      else int_osc_in = 1'b0;
   end
   // offset from the core edge keeps the pin change clear of the sampling instant
   always @(posedge pfd_go) begin
      #3 ref_div_in = 1'b1;
      #(fb_lag_ns) fb_div_in = 1'b1;
      #(HOLD_NS - fb_lag_ns);
      ref_div_in = 1'b0;
      fb_div_in = 1'b0;
   end
endmodule

// *** pllc_top_tb_top.sv ***
// self-checking testbench for the pll and distribution configuration block
`timescale 1ns/1ps
module pllc_top_tb_top;
   import pllc_pkg::*;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic ref_div_in, fb_div_in, ext_clk_in, int_osc_in;
   logic charge_pump_up, charge_pump_dn, charge_pump_hiz;
   logic [2:0] pump_current_code;
   logic [1:0] abp_width_code;
   logic pll_powered_down, int_osc_enable, cal_start, dist_clk;
   logic pfd_go = 1'b0;
   logic [15:0] fb_lag_ns = '0;
   logic [DATA_W-1:0] exp_q[$];
   logic rd_seen = 1'b0;
   logic dist_d = 1'b0;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;
   int cal_cnt = 0;
   int dist_cnt = 0;
   logic [2:0] mode_tab [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
   logic [2:0] pin_tab [5] = '{3'h1, 3'h4, 3'h2, 3'h0, 3'h1};
   logic pol_tab [3] = '{1'b0, 1'b1, 1'b1};
   logic src_tab [3] = '{1'b0, 1'b0, 1'b1};
   logic [1:0] lead_tab [3] = '{2'h2, 2'h1, 2'h2};

   always #12.5 core_clk = ~core_clk;

   pllc_src_model pllc_src_model_i (.int_osc_enable(int_osc_enable), .pfd_go(pfd_go), .fb_lag_ns(fb_lag_ns),
      .ref_div_in(ref_div_in), .fb_div_in(fb_div_in), .ext_clk_in(ext_clk_in), .int_osc_in(int_osc_in));

   pllc_top pllc_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_div_in(ref_div_in), .fb_div_in(fb_div_in),
      .ext_clk_in(ext_clk_in), .int_osc_in(int_osc_in), .charge_pump_up(charge_pump_up),
      .charge_pump_dn(charge_pump_dn), .charge_pump_hiz(charge_pump_hiz), .pump_current_code(pump_current_code),
      .abp_width_code(abp_width_code), .pll_powered_down(pll_powered_down), .int_osc_enable(int_osc_enable),
      .cal_start(cal_start), .dist_clk(dist_clk));

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk(input logic ok, input string what);
      n_tests++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("MISMATCH t=%0t %s", $time, what);
      end
   endtask

   // strobes set each call, so back-to-back transfers never assign a strobe twice
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [8:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge core_clk);
   endtask

   task automatic idle(input int n);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask

   // 320 cycles is 8000 ns, forty external source periods
   task automatic win(output int d);
      int c0;
      c0 = dist_cnt;
      idle(320);
      d = dist_cnt - c0;
   endtask

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      dist_d <= dist_clk;
      if (dist_clk === 1'b1 && dist_d === 1'b0) dist_cnt <= dist_cnt + 1;
      if (cal_start === 1'b1) cal_cnt <= cal_cnt + 1;
      if (rd_seen) begin
         if (exp_q.size() == 0) chk(1'b0, "read data without request");
         else cmp(reg_rdata, exp_q.pop_front(), "read data");
      end
      rd_seen <= reg_rd;
      if (cycles == 6000) begin
         mismatches++;
         $display("MISMATCH t=%0t timeout", $time);
         test_done();
      end
   end

   initial begin
      int c0;
      int d;
      logic [7:0] v;
      void'($urandom(32'he8e2a74f));
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      idle(2);
      cmp(8'({pll_powered_down, int_osc_enable, charge_pump_hiz}), 8'h05, "reset outputs");
      rd(OFS_PLL_MAIN, 8'h01);
      rd(OFS_DIST_SEL, 8'h00);
      rd(OFS_DIV_SEL, 8'h02);
      rd(OFS_PUMP_CUR, 8'h07);
      wr(9'h100, 8'ha5);
      rd(9'h100, 8'h00);
      idle(4);
      win(d);
      chk(d >= 9 && d <= 11, "divided distribution clock");
      wr(OFS_DIV_SEL, 8'h00);
      idle(50);
      win(d);
      chk(d >= 19 && d <= 21, "prescaler divide by two");
      // codes above the top clamp to the largest divide
      wr(OFS_DIV_SEL, 8'h07);
      idle(50);
      win(d);
      chk(d >= 6 && d <= 7, "prescaler clamped to six");
      for (int i = 0; i < 8; i++) begin
         v = 8'($urandom_range(3));
         wr(OFS_DET_CTL, v);
         rd(OFS_DET_CTL, v);
         wr(OFS_PUMP_CUR, 8'(i));
         rd(OFS_PUMP_CUR, 8'(i));
         idle(3);
         cmp(8'(abp_width_code), v, "width code");
         cmp(8'(pump_current_code), 8'(i), "current code");
      end
      wr(OFS_PLL_MAIN, 8'h30);
      idle(3);
      cmp(8'(pll_powered_down), 8'h00, "pll on");
      for (int k = 0; k < 5; k++) begin
         wr(OFS_PLL_MAIN, {1'b0, mode_tab[k], 4'h0});
         idle(3);
         cmp(8'({charge_pump_up, charge_pump_dn, charge_pump_hiz}), 8'(pin_tab[k]), "pump mode");
      end
      wr(OFS_PLL_MAIN, 8'h31);
      idle(3);
      cmp(8'({pll_powered_down, charge_pump_hiz}), 8'h03, "pll off");
      for (int k = 0; k < 3; k++) begin
         wr(OFS_DIST_SEL, {6'h0, src_tab[k], 1'b1});
         wr(OFS_PLL_MAIN, {pol_tab[k], 7'h30});
         idle(4);
         fb_lag_ns <= 16'h1f4;
         pfd_go <= 1'b1;
         idle(8);
         cmp(8'({charge_pump_up, charge_pump_dn}), 8'(lead_tab[k]), "leading pump");
         idle(40);
         cmp(8'({charge_pump_up, charge_pump_dn}), 8'h00, "pumps released");
         pfd_go <= 1'b0;
      end
      // software puts the pll in normal operation with the divider bypassed
      wr(OFS_DIST_SEL, 8'h01);
      wr(OFS_PLL_MAIN, 8'h30);
      for (int c = 0; c < 4; c++) begin
         wr(OFS_DET_CTL, 8'(c));
         idle(4);
         fb_lag_ns <= 16'h0;
         pfd_go <= 1'b1;
         d = 0;
         repeat (44) begin
            @(posedge core_clk);
            if (charge_pump_up === 1'b1 && charge_pump_dn === 1'b1) d++;
         end
         pfd_go <= 1'b0;
         chk(d == c + 2, "antibacklash length");
      end
      win(d);
      chk(d >= 38 && d <= 41, "bypassed external clock");
      wr(OFS_DIST_SEL, 8'h03);
      idle(4);
      cmp(8'(int_osc_enable), 8'h01, "oscillator enabled");
      win(d);
      chk(d >= 25 && d <= 28, "bypassed internal oscillator");
      c0 = cal_cnt;
      // calibration rearmed then started once the loop is set up
      wr(OFS_CAL_CTL, 8'h00);
      wr(OFS_CAL_CTL, 8'h01);
      idle(4);
      chk(cal_cnt - c0 == 1, "calibration pulse");
      // oscillator goes dark with the pll off, so the status word is steady
      wr(OFS_PLL_MAIN, 8'h31);
      idle(16);
      rd(OFS_STATUS, 8'h00);
      wr(OFS_PLL_MAIN, 8'h30);
      idle(1);
      rd(OFS_STATUS, 8'h07);
      idle(2);
      test_done();
   end
endmodule
